/* File: ppl_top.sv */
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`include "ppl_map.svh"
module ppl_top
   import ppl_pkg::*;
#(
   parameter int unsigned SAMPLE_CYCLES = `PPL_SAMPLE_US * `PPL_CLK_MHZ
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [11:0] adc_data,
   input  wire logic        adc_done,
   output logic             adc_start,
   output ppl_word_t        set_value,
   output logic             set_value_strobe
);

   localparam int CW = $clog2(SAMPLE_CYCLES + 1);
   localparam logic [CW-1:0] TICK_LAST = CW'(SAMPLE_CYCLES - 1);

   logic                    aw_held_r;
   logic [7:0]              aw_addr_r;
   logic                    w_held_r;
   logic [31:0]             wdata_r;
   logic [3:0]              wstrb_r;
   logic                    do_write;
   logic [1:0]              wr_resp;
   logic                    wr_coeff;
   logic [31:0]             rd_data;
   logic [1:0]              rd_resp;
   logic [`PPL_CTRL_W-1:0]  ctrl_r;
   logic [15:0]             cmd_r;
   logic [15:0]             kp_r;
   logic [15:0]             ki_r;
   logic [15:0]             kd_r;
   logic [15:0]             win_r;
   logic [15:0]             ired_r;
   logic [15:0]             kff_r;
   logic [15:0]             db_a_r;
   logic [15:0]             db_b_r;
   logic [11:0]             adc_s;
   logic                    done_s;
   logic                    done_prev_r;
   logic [11:0]             fb_raw_r;
   logic [CW-1:0]           tick_cnt_r;
   logic                    tick_r;
   ppl_word_t               acc_r;
   logic signed [16:0]      fb_prev_r;
   ppl_mode_t               mode;
   logic                    access_level_a;
   logic signed [16:0]      cmd_ext;
   logic signed [16:0]      cmd_s;
   logic signed [16:0]      fb_c;
   logic signed [16:0]      fb_s;
   logic signed [17:0]      err;
   logic [17:0]             err_abs;
   logic signed [34:0]      p_t;
   logic signed [34:0]      i_t;
   logic signed [51:0]      i_red;
   ppl_wide_t               i_use;
   ppl_word_t               acc_nxt;
   logic signed [17:0]      dfb;
   logic signed [33:0]      d_t;
   logic signed [33:0]      ff_t;
   ppl_wide_t               db_t;
   ppl_wide_t               sum_all;
   ppl_word_t               set_value_nxt;
   ppl_word_t               p_only_sat;

   function automatic ppl_word_t ppl_sat(input ppl_wide_t v);
      if (v > `PPL_OUT_MAX) begin
         return `PPL_SAT_HI;
      end else if (v < `PPL_OUT_MIN) begin
         return `PPL_SAT_LO;
      end
      return v[15:0];
   endfunction

   function automatic logic [15:0] ppl_merge(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  be);
      return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction

   assign mode   = ppl_mode_t'(ctrl_r[`PPL_CTRL_MODE_HI:`PPL_CTRL_MODE_LO]);
   assign access_level_a = ctrl_r[`PPL_CTRL_ACCESS_LEVEL_A];

   // write address channel
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_held_r     <= 1'b0;
         aw_addr_r     <= 8'h00;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r     <= 1'b1;
         aw_addr_r     <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         aw_held_r     <= 1'b0;
         s_axi_awready <= 1'b1;
      end
   end

   // write data channel
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         w_held_r     <= 1'b0;
         wdata_r      <= 32'h0000_0000;
         wstrb_r      <= 4'h0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r     <= 1'b1;
         wdata_r      <= s_axi_wdata;
         wstrb_r      <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         w_held_r     <= 1'b0;
         s_axi_wready <= 1'b1;
      end
   end

   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

   // write decode; coefficients locked outside access_level_a level
   always_comb begin
      wr_coeff = 1'b0;
      wr_resp  = `PPL_RESP_OKAY;
      case (aw_addr_r)
         `PPL_OFF_CTRL, `PPL_OFF_COMMAND, `PPL_OFF_DB_A, `PPL_OFF_DB_B: begin
            wr_resp = `PPL_RESP_OKAY;
         end
         `PPL_OFF_KP, `PPL_OFF_KI, `PPL_OFF_KD, `PPL_OFF_WINDOW, `PPL_OFF_IRED,
         `PPL_OFF_KFF: begin
            wr_coeff = 1'b1;
            wr_resp  = access_level_a ? `PPL_RESP_OKAY : `PPL_RESP_SLVERR;
         end
         `PPL_OFF_SETVAL, `PPL_OFF_FEEDBACK, `PPL_OFF_INTEG: begin
            wr_resp = `PPL_RESP_SLVERR;
         end
         default: begin
            wr_resp = `PPL_RESP_DECERR;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PPL_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_resp;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // parameter registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r <= `PPL_RST_CTRL;
         cmd_r  <= `PPL_RST_REG;
         kp_r   <= `PPL_RST_REG;
         ki_r   <= `PPL_RST_REG;
         kd_r   <= `PPL_RST_REG;
         win_r  <= `PPL_RST_REG;
         ired_r <= `PPL_RST_REG;
         kff_r  <= `PPL_RST_REG;
         db_a_r <= `PPL_RST_REG;
         db_b_r <= `PPL_RST_REG;
      end else if (do_write && (!wr_coeff || access_level_a)) begin
         case (aw_addr_r)
            `PPL_OFF_CTRL: begin
               if (wstrb_r[0]) begin
                  ctrl_r <= wdata_r[`PPL_CTRL_W-1:0];
               end
            end
            `PPL_OFF_COMMAND: cmd_r  <= ppl_merge(cmd_r, wdata_r, wstrb_r);
            `PPL_OFF_KP:      kp_r   <= ppl_merge(kp_r, wdata_r, wstrb_r);
            `PPL_OFF_KI:      ki_r   <= ppl_merge(ki_r, wdata_r, wstrb_r);
            `PPL_OFF_KD:      kd_r   <= ppl_merge(kd_r, wdata_r, wstrb_r);
            `PPL_OFF_WINDOW:  win_r  <= ppl_merge(win_r, wdata_r, wstrb_r);
            `PPL_OFF_IRED:    ired_r <= ppl_merge(ired_r, wdata_r, wstrb_r);
            `PPL_OFF_KFF:     kff_r  <= ppl_merge(kff_r, wdata_r, wstrb_r);
            `PPL_OFF_DB_A:    db_a_r <= ppl_merge(db_a_r, wdata_r, wstrb_r);
            `PPL_OFF_DB_B:    db_b_r <= ppl_merge(db_b_r, wdata_r, wstrb_r);
            default: begin
            end
         endcase
      end
   end

   // read mux
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_resp = `PPL_RESP_OKAY;
      case (s_axi_araddr)
         `PPL_OFF_CTRL:     rd_data = {27'h0, ctrl_r};
         `PPL_OFF_COMMAND:  rd_data = {16'h0, cmd_r};
         `PPL_OFF_KP:       rd_data = {16'h0, kp_r};
         `PPL_OFF_KI:       rd_data = {16'h0, ki_r};
         `PPL_OFF_KD:       rd_data = {16'h0, kd_r};
         `PPL_OFF_WINDOW:   rd_data = {16'h0, win_r};
         `PPL_OFF_IRED:     rd_data = {16'h0, ired_r};
         `PPL_OFF_KFF:      rd_data = {16'h0, kff_r};
         `PPL_OFF_DB_A:     rd_data = {16'h0, db_a_r};
         `PPL_OFF_DB_B:     rd_data = {16'h0, db_b_r};
         `PPL_OFF_SETVAL:   rd_data = {16'h0, set_value};
         `PPL_OFF_FEEDBACK: rd_data = {20'h0, fb_raw_r};
         `PPL_OFF_INTEG:    rd_data = {16'h0, acc_r};
         default:           rd_resp = `PPL_RESP_DECERR;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `PPL_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_data;
         s_axi_rresp   <= rd_resp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   // converter interface
   ppl_sync #(.WIDTH(12)) u_sync_data (
      .clk  (clk),
      .nrst (nrst),
      .din  (adc_data),
      .dout (adc_s)
   );

   ppl_sync #(.WIDTH(1)) u_sync_done (
      .clk  (clk),
      .nrst (nrst),
      .din  (adc_done),
      .dout (done_s)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         done_prev_r <= 1'b0;
         fb_raw_r    <= `PPL_RST_ADC;
      end else begin
         done_prev_r <= done_s;
         if (done_s && !done_prev_r) begin
            fb_raw_r <= adc_s;
         end
      end
   end

   // sample period timer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
         adc_start  <= 1'b0;
      end else begin
         tick_r     <= (tick_cnt_r == TICK_LAST);
         adc_start  <= (tick_cnt_r == TICK_LAST);
         tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + 1'b1;
      end
   end

   // control law
   assign cmd_ext = {cmd_r[15], cmd_r};
   assign cmd_s   = ctrl_r[`PPL_CTRL_CMD_INV] ? -cmd_ext : cmd_ext;
   assign fb_c    = ($signed({5'h00, fb_raw_r}) - `PPL_ADC_MID) <<< `PPL_FB_SHIFT;
   assign fb_s    = ctrl_r[`PPL_CTRL_FB_INV] ? -fb_c : fb_c;
   assign err     = {cmd_s[16], cmd_s} - {fb_s[16], fb_s};
   assign err_abs = err[17] ? 18'(-err) : 18'(err);
   assign p_t     = ($signed({1'b0, kp_r}) * err) >>> `PPL_QSHIFT;
   assign i_t     = ($signed({1'b0, ki_r}) * err) >>> `PPL_QSHIFT;
   assign i_red   = ($signed({1'b0, ired_r}) * i_t) >>> `PPL_QSHIFT;
   assign i_use   = (err_abs <= {2'b00, win_r}) ? 40'(i_t) : 40'(i_red);
   assign dfb     = {fb_s[16], fb_s} - {fb_prev_r[16], fb_prev_r};
   assign d_t     = ($signed(kd_r) * dfb) >>> `PPL_QSHIFT;
   assign ff_t    = ($signed({1'b0, kff_r}) * cmd_s) >>> `PPL_QSHIFT;

   // side A for positive command, side B for negative
   always_comb begin
      db_t = 40'sh00_0000_0000;
      if (cmd_s > 17'sh00000) begin
         db_t = 40'($signed({1'b0, db_a_r}));
      end else if (cmd_s < 17'sh00000) begin
         db_t = -40'($signed({1'b0, db_b_r}));
      end
   end

   always_comb begin
      acc_nxt = 16'sh0000;
      sum_all = 40'(cmd_s) + db_t;
      case (mode)
         PPL_MODE_CLOSED: begin
            if (win_r != 16'h0000) begin
               acc_nxt = ppl_sat(40'(acc_r) + i_use);
            end
            sum_all = 40'(p_t) + 40'(acc_nxt) + 40'(d_t) + 40'(ff_t) + db_t;
         end
         default: begin
            acc_nxt = 16'sh0000;
         end
      endcase
   end

   assign set_value_nxt = ppl_sat(sum_all);
   assign p_only_sat    = ppl_sat(40'(p_t));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc_r            <= 16'sh0000;
         fb_prev_r        <= 17'sh00000;
         set_value        <= 16'sh0000;
         set_value_strobe <= 1'b0;
      end else begin
         set_value_strobe <= tick_r;
         if (tick_r) begin
            acc_r     <= acc_nxt;
            fb_prev_r <= fb_s;
            set_value <= set_value_nxt;
         end
      end
   end

   AST_STROBE_SPACING:
   assert property (@(posedge clk) disable iff (!nrst)
      tick_r |-> $past(tick_cnt_r) == TICK_LAST)
      else $error("update tick not at end of sample period");

   AST_STROBE_FOLLOWS_TICK:
   assert property (@(posedge clk) disable iff (!nrst)
      set_value_strobe |-> $past(tick_r) && !tick_r)
      else $error("set value strobe without a tick");

   AST_OPEN_ZERO_CMD:
   assert property (@(posedge clk) disable iff (!nrst)
      tick_r && mode == PPL_MODE_OPEN && cmd_r == 16'h0000 |=> set_value == 16'sh0000)
      else $error("open loop with zero command gave nonzero output");

   AST_WINDOW_ZERO_CLEARS:
   assert property (@(posedge clk) disable iff (!nrst)
      tick_r && win_r == 16'h0000 |=> acc_r == 16'sh0000)
      else $error("integrator active with window zero");

   AST_P_ONLY:
   assert property (@(posedge clk) disable iff (!nrst)
      tick_r && mode == PPL_MODE_CLOSED && ki_r == 16'h0000 && kd_r == 16'h0000
      && kff_r == 16'h0000 && win_r == 16'h0000 && db_a_r == 16'h0000
      && db_b_r == 16'h0000 |=> set_value == $past(p_only_sat))
      else $error("output differs from proportional term alone");

   AST_SAT_HIGH:
   assert property (@(posedge clk) disable iff (!nrst)
      tick_r && sum_all > `PPL_OUT_MAX |=> set_value == `PPL_SAT_HI ##1 set_value_strobe == 1'b0)
      else $error("output not clamped at positive limit");

   AST_INTEG_HOLDS_AT_ZERO_ERR:
   assert property (@(posedge clk) disable iff (!nrst)
      tick_r && mode == PPL_MODE_CLOSED && win_r != 16'h0000 && err == 18'sh00000
      |=> acc_r == $past(acc_r))
      else $error("integrator moved with zero error");

   AST_COEFF_LOCK:
   assert property (@(posedge clk) disable iff (!nrst)
      do_write && !access_level_a && aw_addr_r == `PPL_OFF_KP
      |=> kp_r == $past(kp_r) && s_axi_bvalid && s_axi_bresp == `PPL_RESP_SLVERR)
      else $error("coefficient written outside access_level_a level");

endmodule

/* File: ppl_map.svh */
`ifndef PPL_MAP_SVH
`define PPL_MAP_SVH

// register byte offsets
`define PPL_OFF_CTRL      8'h00
`define PPL_OFF_COMMAND   8'h04
`define PPL_OFF_KP        8'h08
`define PPL_OFF_KI        8'h0c
`define PPL_OFF_KD        8'h10
`define PPL_OFF_WINDOW    8'h14
`define PPL_OFF_IRED      8'h18
`define PPL_OFF_KFF       8'h1c
`define PPL_OFF_DB_A      8'h20
`define PPL_OFF_DB_B      8'h24
`define PPL_OFF_SETVAL    8'h28
`define PPL_OFF_FEEDBACK  8'h2c
`define PPL_OFF_INTEG     8'h30

// control fields
`define PPL_CTRL_W        5
`define PPL_CTRL_MODE_HI  1
`define PPL_CTRL_MODE_LO  0
`define PPL_CTRL_CMD_INV  2
`define PPL_CTRL_FB_INV   3
`define PPL_CTRL_ACCESS_LEVEL_A   4

// reset values
`define PPL_RST_CTRL      5'h00
`define PPL_RST_REG       16'h0000
`define PPL_RST_ADC       12'h000

// bus answers
`define PPL_RESP_OKAY     2'h0
`define PPL_RESP_SLVERR   2'h2
`define PPL_RESP_DECERR   2'h3

// timing: one update per period at the clock rate
`define PPL_SAMPLE_US     1000
`define PPL_CLK_MHZ       25

// arithmetic scaling
`define PPL_QSHIFT        8
`define PPL_FB_SHIFT      3
`define PPL_ADC_MID       17'sh00800
`define PPL_OUT_MAX       40'sh00_0000_7fff
`define PPL_OUT_MIN       40'shff_ffff_8000
`define PPL_SAT_HI        16'sh7fff
`define PPL_SAT_LO        16'sh8000

`endif

/* File: ppl_pkg.sv */
package ppl_pkg;

   typedef enum logic [1:0] {
      PPL_MODE_OPEN   = 2'b00,
      PPL_MODE_RSVD   = 2'b01,
      PPL_MODE_CLOSED = 2'b10,
      PPL_MODE_RSVD3  = 2'b11
   } ppl_mode_t;

   typedef logic signed [15:0] ppl_word_t;
   typedef logic signed [39:0] ppl_wide_t;

endpackage

/* File: ppl_sync.sv */
module ppl_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   // three stages; output follows once stages two and three agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         dout <= '0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            dout <= s3_r;
         end
      end
   end

endmodule

/* File: ppl_adc_model.sv */
module ppl_adc_model #(
   parameter int unsigned DONE_AT = 8
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        adc_start,
   input  wire logic [11:0] pos,
   output logic      [11:0] adc_data,
   output logic             adc_done
);
   timeunit 1ns;
   timeprecision 1ps;

   int unsigned cnt_r;

   // latch position on request, done only after data has been stable a while
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r    <= 32'h0;
         adc_data <= 12'h800;
         adc_done <= 1'h0;
      end else if (adc_start) begin
         cnt_r    <= 32'h1;
         adc_data <= pos;
         adc_done <= 1'h0;
      end else if (cnt_r != 32'h0) begin
         cnt_r    <= (cnt_r == DONE_AT + 32'h4) ? 32'h0 : cnt_r + 32'h1;
         adc_done <= (cnt_r >= DONE_AT) && (cnt_r < DONE_AT + 32'h4);
      end
   end
endmodule

/* File: position_pid_loop_tb_top.sv */
`include "ppl_map.svh"
module position_pid_loop_tb_top
   import ppl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned SC = 20;

   logic        clk, nrst;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] adc_data, pos;
   logic        adc_done, adc_start, set_value_strobe;
   ppl_word_t   set_value, v, w;
   int          err_total, n_compared, n;

   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   ppl_top #(.SAMPLE_CYCLES(SC)) dut (
      .clk              (clk),
      .nrst             (nrst),
      .s_axi_awaddr     (s_axi_awaddr),
      .s_axi_awvalid    (s_axi_awvalid),
      .s_axi_awready    (s_axi_awready),
      .s_axi_wdata      (s_axi_wdata),
      .s_axi_wstrb      (s_axi_wstrb),
      .s_axi_wvalid     (s_axi_wvalid),
      .s_axi_wready     (s_axi_wready),
      .s_axi_bresp      (s_axi_bresp),
      .s_axi_bvalid     (s_axi_bvalid),
      .s_axi_bready     (s_axi_bready),
      .s_axi_araddr     (s_axi_araddr),
      .s_axi_arvalid    (s_axi_arvalid),
      .s_axi_arready    (s_axi_arready),
      .s_axi_rdata      (s_axi_rdata),
      .s_axi_rresp      (s_axi_rresp),
      .s_axi_rvalid     (s_axi_rvalid),
      .s_axi_rready     (s_axi_rready),
      .adc_data         (adc_data),
      .adc_done         (adc_done),
      .adc_start        (adc_start),
      .set_value        (set_value),
      .set_value_strobe (set_value_strobe)
   );

   ppl_adc_model adc (
      .clk       (clk),
      .nrst      (nrst),
      .adc_start (adc_start),
      .pos       (pos),
      .adc_data  (adc_data),
      .adc_done  (adc_done)
   );

   task automatic chk(input logic signed [31:0] seen, input logic signed [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %0d expected %0d", $time, seen, exp);
      end
   endtask

   // bus write, called right after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      forever begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) break;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge clk);
   endtask

   task automatic rdr(input logic [7:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      forever begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) break;
      end
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge clk);
   endtask

   // wait for the next update pulse, return edges waited
   task automatic sv(output int cyc);
      cyc = 0;
      do begin
         @(posedge clk);
         cyc++;
      end while (set_value_strobe !== 1'h1 && cyc < 100);
      v = set_value;
      if (set_value_strobe !== 1'h1) begin
         err_total++;
         stop_test();
      end
   endtask

   task automatic settle(input int e);
      repeat (3) sv(n);
      chk(v, e);
   endtask

   // step of output between two updates
   task automatic igrow(input int e);
      repeat (2) sv(n);
      w = v;
      sv(n);
      chk(v - w, e);
   endtask

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test();
   end

   initial begin
      err_total = 0;
      n_compared = 0;
      nrst = 1'h0;
      pos = 12'h864;
      s_axi_wstrb = 4'hf;
      {s_axi_awaddr, s_axi_araddr} = 16'h0000;
      s_axi_wdata = 32'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      // locked coefficients, unmapped place
      rdr(`PPL_OFF_CTRL);
      chk(rd, 0);
      wr(`PPL_OFF_KP, 32'h0000_0100);
      chk(resp, `PPL_RESP_SLVERR);
      rdr(`PPL_OFF_KP);
      chk(rd, 0);
      rdr(8'h40);
      chk(resp, `PPL_RESP_DECERR);
      // open loop with dead band
      wr(`PPL_OFF_CTRL, 32'h0000_0010);
      wr(`PPL_OFF_COMMAND, 32'h0000_03e8);
      wr(`PPL_OFF_DB_A, 32'h0000_0032);
      wr(`PPL_OFF_DB_B, 32'h0000_001e);
      settle(1050);
      wr(`PPL_OFF_COMMAND, 32'h0000_fc18);
      settle(-1030);
      wr(`PPL_OFF_CTRL, 32'h0000_0014);
      wr(`PPL_OFF_COMMAND, 32'h0000_03e8);
      settle(-1030);
      wr(`PPL_OFF_COMMAND, 32'h0);
      settle(0);
      wr(`PPL_OFF_COMMAND, 32'h0000_03e8);
      // closed loop, proportional, then proportional with feedforward
      wr(`PPL_OFF_DB_A, 32'h0);
      wr(`PPL_OFF_DB_B, 32'h0);
      wr(`PPL_OFF_KP, 32'h0000_0100);
      wr(`PPL_OFF_CTRL, 32'h0000_0012);
      settle(200);
      rdr(`PPL_OFF_FEEDBACK);
      chk(rd, 32'h0000_0864);
      sv(n);
      sv(n);
      chk(n, SC);
      wr(`PPL_OFF_CTRL, 32'h0000_001a);
      settle(1800);
      wr(`PPL_OFF_CTRL, 32'h0000_0012);
      wr(`PPL_OFF_KFF, 32'h0000_0100);
      settle(1200);
      wr(`PPL_OFF_KFF, 32'h0);
      wr(`PPL_OFF_KP, 32'h0000_ffff);
      settle(32767);
      wr(`PPL_OFF_KP, 32'h0);
      // derivative, both signs
      wr(`PPL_OFF_KD, 32'h0000_0100);
      settle(0);
      pos <= 12'h86e;
      sv(n);
      sv(n);
      chk(v, 80);
      sv(n);
      chk(v, 0);
      wr(`PPL_OFF_KD, 32'h0000_ff00);
      pos <= 12'h864;
      settle(0);
      pos <= 12'h86e;
      sv(n);
      sv(n);
      chk(v, -80);
      // integral inside and outside the window
      wr(`PPL_OFF_KD, 32'h0);
      pos <= 12'h864;
      wr(`PPL_OFF_KI, 32'h0000_0100);
      settle(0);
      rdr(`PPL_OFF_INTEG);
      chk(rd, 0);
      wr(`PPL_OFF_WINDOW, 32'h0000_03e8);
      igrow(200);
      wr(`PPL_OFF_IRED, 32'h0000_0080);
      wr(`PPL_OFF_WINDOW, 32'h0000_0064);
      igrow(100);
      // feedback equal to command, integrator must hold
      pos <= 12'h87d;
      igrow(0);
      stop_test();
   end
endmodule
